/* File: tcw_pkg.sv */
`default_nettype none
package tcw_pkg;

    // Command codes on command bits 1:0
    localparam logic [1:0] CODE_WRITE  = 2'h1;
    localparam logic [1:0] CODE_SEARCH = 2'h2;
    // Command field positions
    localparam int CMD_W       = 9;
    localparam int CMD_TYPE    = 2;
    localparam int CMD_MIDX_LO = 3;
    localparam int CMD_SHI_LO  = 6;
    // Data bus layout
    localparam int DQ_W        = 68;
    localparam int DQ_IND      = 29;
    localparam int DQ_RES_LO   = 26;
    localparam int DQ_ID_LO    = 21;
    localparam int DQ_TGT_LO   = 19;
    localparam logic [4:0] ID_ALL = 5'h1F;
    // Search answer latency and hit delay range
    localparam int SRCH_LAT    = 4;
    localparam int HDLY_MAX    = 7;

    // APB register offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_ADDR   = 8'h04;
    localparam logic [7:0] OFF_DATA0  = 8'h08;
    localparam logic [7:0] OFF_DATA1  = 8'h0C;
    localparam logic [7:0] OFF_DATA2  = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_RESULT = 8'h18;
    // Control register fields
    localparam int CTL_GO      = 0;
    localparam int CTL_KIND    = 1;
    localparam int CTL_BURST   = 2;
    localparam int CTL_MIDX_LO = 4;
    localparam int CTL_SHI_LO  = 8;
    localparam int CTL_RES_LO  = 12;
    localparam int CTL_CMP_LO  = 16;
    localparam int CTL_BURST_LENGTH_LO = 20;
    localparam int CTL_HDLY_LO = 28;

    typedef enum logic [2:0] {
        TCW_IDLE  = 3'h0,
        TCW_CYC_A = 3'h1,
        TCW_CYC_B = 3'h2,
        TCW_DATA  = 3'h3,
        TCW_TAIL  = 3'h4,
        TCW_WAIT  = 3'h5
    } tcw_state_t;

    // Pins toward the search engine
    typedef struct packed {
        logic              cmd_valid;
        logic [CMD_W-1:0]  cmd;
        logic [DQ_W-1:0]   dq_out;
        logic              dq_oe;
    } tcw_pins_t;

    typedef struct packed {
        tcw_state_t        st;
        tcw_pins_t         pins;
        logic [31:0]       ctrl;
        logic [31:0]       addr;
        logic [DQ_W-1:0]   data;
        logic [7:0]        cnt;
        logic              busy;
        logic              done;
        logic              bend_seen;
        logic              found;
        logic [21:0]       res_addr;
        logic [31:0]       prdata;
        logic              pready;
        logic              bend_s1;
        logic              bend_s2;
        logic              sval_s1;
        logic              sval_s2;
        logic              sfnd_s1;
        logic              sfnd_s2;
        logic [21:0]       sram_s1;
        logic [21:0]       sram_s2;
    } tcw_regs_t;

endpackage
`default_nettype wire

/* File: tcw_host.sv */
// Notes on behaviour
// - Command bit 2 low means single write, high means burst array write.
// - Single write takes three cycles; each extra burst location adds one.
// - Write cycle A: valid, code 01, address word on bus, mask index bits 5:3.
// - SRAM writes carry upper SRAM address bits on command bits 8:6.
// - Cycle B repeats command; device ID on bus bits 25:21, all ones broadcasts.
// - Single write data in cycle 2, cycle 3 idle, then next operation.
// - Burst write lasts burst length plus two cycles; the host holds one more idle cycle for the synced end flag.
// - Burst config must be loaded before issuing a burst write.
// - Burst cycles 2 to n+1 carry data for successive locations.
// - Search cycle A: valid, code 10, bit 2 low, mask pair index, key.
// - Search cycle A bits 8:6 become upper SRAM address bits on a hit.
// - Search cycle B: code 10, comparand index 5:2, result index 8:6.
// - Same key in both search cycles; mask pair programmed identical.
// - Write code is 01; read 00, search 10, learn 11.
`timescale 1ns/10ps
`default_nettype none
module tcw_host (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      clk_en,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [7:0]                paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    output logic                           command_valid,
    output logic      [tcw_pkg::CMD_W-1:0] command,
    output logic      [tcw_pkg::DQ_W-1:0]  data_bus_out,
    output logic                           data_bus_oe,
    input  wire logic                      burst_end_flag,
    input  wire logic                      search_valid_out,
    input  wire logic                      search_found_out,
    input  wire logic [21:0]               sram_addr
);

    tcw_pkg::tcw_regs_t r_r;
    tcw_pkg::tcw_regs_t r_nxt;

    // Full 68-bit word from the three staging registers
    function automatic logic [tcw_pkg::DQ_W-1:0] word68(input logic [31:0] a,
                                                        input logic [31:0] b,
                                                        input logic [31:0] c);
        word68 = {c[3:0], b, a};
    endfunction

    logic wr_acc;
    logic rd_acc;
    logic is_srch;
    logic is_burst;
    logic [7:0] burst_length;
    logic [3:0] hit_wait;
    assign wr_acc   = psel && penable && pwrite;
    assign rd_acc   = psel && !penable && !pwrite;
    assign is_srch  = r_r.ctrl[tcw_pkg::CTL_KIND];
    assign is_burst = r_r.ctrl[tcw_pkg::CTL_BURST];
    assign burst_length     = r_r.ctrl[tcw_pkg::CTL_BURST_LENGTH_LO +: 8];
    assign hit_wait = 4'(tcw_pkg::SRCH_LAT) + {1'b0, r_r.ctrl[tcw_pkg::CTL_HDLY_LO +: 3]};

    // Next-state logic: APB slave, command sequencer, pin synchronisers
    always_comb begin
        r_nxt = r_r;
        r_nxt.pready = 1'b0;
        // Pins from the engine pass two flops before use
        r_nxt.bend_s1 = burst_end_flag;
        r_nxt.bend_s2 = r_r.bend_s1;
        r_nxt.sval_s1 = search_valid_out;
        r_nxt.sval_s2 = r_r.sval_s1;
        r_nxt.sfnd_s1 = search_found_out;
        r_nxt.sfnd_s2 = r_r.sfnd_s1;
        r_nxt.sram_s1 = sram_addr;
        r_nxt.sram_s2 = r_r.sram_s1;

        // Register reads answer in the access phase (one wait-free cycle)
        if (psel && !penable) begin
            r_nxt.pready = 1'b1;
        end
        if (rd_acc) begin
            unique case (paddr)
                tcw_pkg::OFF_CTRL:   r_nxt.prdata = r_r.ctrl;
                tcw_pkg::OFF_ADDR:   r_nxt.prdata = r_r.addr;
                tcw_pkg::OFF_DATA0:  r_nxt.prdata = r_r.data[31:0];
                tcw_pkg::OFF_DATA1:  r_nxt.prdata = r_r.data[63:32];
                tcw_pkg::OFF_DATA2:  r_nxt.prdata = {28'h0000000, r_r.data[67:64]};
                tcw_pkg::OFF_STATUS: r_nxt.prdata = {28'h0000000, r_r.found,
                                                     r_r.bend_seen, r_r.done, r_r.busy};
                tcw_pkg::OFF_RESULT: r_nxt.prdata = {10'h000, r_r.res_addr};
                default:             r_nxt.prdata = 32'h00000000;
            endcase
        end

        // Writes land at the access edge; staging is frozen while busy
        if (wr_acc && r_r.pready && !r_r.busy) begin
            unique case (paddr)
                tcw_pkg::OFF_CTRL:  r_nxt.ctrl = pwdata;
                tcw_pkg::OFF_ADDR:  r_nxt.addr = pwdata;
                tcw_pkg::OFF_DATA0: r_nxt.data[31:0] = pwdata;
                tcw_pkg::OFF_DATA1: r_nxt.data[63:32] = pwdata;
                tcw_pkg::OFF_DATA2: r_nxt.data[67:64] = pwdata[3:0];
                default: ;
            endcase
        end

        unique case (r_r.st)
            tcw_pkg::TCW_IDLE: begin
                r_nxt.pins = '0;
                if (r_nxt.ctrl[tcw_pkg::CTL_GO] && !r_r.busy) begin
                    r_nxt.busy = 1'b1;
                    r_nxt.done = 1'b0;
                    r_nxt.bend_seen = 1'b0;
                    r_nxt.ctrl[tcw_pkg::CTL_GO] = 1'b0;
                    r_nxt.st = tcw_pkg::TCW_CYC_A;
                    r_nxt.pins.cmd_valid = 1'b1;
                    r_nxt.pins.dq_oe = 1'b1;
                    if (r_nxt.ctrl[tcw_pkg::CTL_KIND]) begin
                        // Search cycle A: key on bus, mask pair, upper SRAM bits
                        r_nxt.pins.cmd = {r_nxt.ctrl[tcw_pkg::CTL_SHI_LO +: 3],
                                          r_nxt.ctrl[tcw_pkg::CTL_MIDX_LO +: 3],
                                          1'b0, tcw_pkg::CODE_SEARCH};
                        r_nxt.pins.dq_out = r_nxt.data;
                    end else begin
                        // Write cycle A: address word and mask index
                        r_nxt.pins.cmd = {r_nxt.ctrl[tcw_pkg::CTL_SHI_LO +: 3],
                                          r_nxt.ctrl[tcw_pkg::CTL_MIDX_LO +: 3],
                                          r_nxt.ctrl[tcw_pkg::CTL_BURST],
                                          tcw_pkg::CODE_WRITE};
                        r_nxt.pins.dq_out = {36'h000000000, r_nxt.addr};
                    end
                end
            end
            tcw_pkg::TCW_CYC_A: begin
                r_nxt.st = tcw_pkg::TCW_CYC_B;
                if (is_srch) begin
                    // Same key again; comparand and result indices
                    r_nxt.pins.cmd = {r_r.ctrl[tcw_pkg::CTL_RES_LO +: 3],
                                      r_r.ctrl[tcw_pkg::CTL_CMP_LO +: 4],
                                      tcw_pkg::CODE_SEARCH};
                end else begin
                    // Cycle B repeats command; SRAM bits zero here
                    r_nxt.pins.cmd[8:6] = 3'h0;
                end
            end
            tcw_pkg::TCW_CYC_B: begin
                r_nxt.pins.cmd_valid = 1'b0;
                r_nxt.pins.cmd = '0;
                r_nxt.cnt = 8'h00;
                if (is_srch) begin
                    // Wait for latched answer; no new search until then
                    r_nxt.pins.dq_oe = 1'b0;
                    r_nxt.st = tcw_pkg::TCW_WAIT;
                end else begin
                    r_nxt.pins.dq_out = r_r.data;
                    r_nxt.st = tcw_pkg::TCW_DATA;
                end
            end
            tcw_pkg::TCW_DATA: begin
                // Burst: data for each following location, one per cycle
                if (is_burst && (r_r.cnt + 8'h01 < burst_length)) begin
                    r_nxt.cnt = r_r.cnt + 8'h01;
                    r_nxt.pins.dq_out = r_r.data + 68'(r_nxt.cnt);
                end else begin
                    r_nxt.pins.dq_oe = 1'b0;
                    r_nxt.pins.dq_out = '0;
                    r_nxt.cnt = 8'h00;
                    r_nxt.st = tcw_pkg::TCW_TAIL;
                end
            end
            tcw_pkg::TCW_TAIL: begin
                // Idle cycle (single) or final flag-low cycle (burst); a burst stays
                // one cycle longer because its end flag comes through two sync flops
                r_nxt.cnt = r_r.cnt + 8'h01;
                if (!is_burst || r_r.cnt == 8'h01) begin
                    r_nxt.st = tcw_pkg::TCW_IDLE;
                    r_nxt.busy = 1'b0;
                    r_nxt.done = 1'b1;
                end
                // Only the synced last-data-cycle flag counts; the released line is noise
                if (is_burst && r_r.cnt == 8'h01) begin
                    r_nxt.bend_seen = r_r.bend_s2;
                end
            end
            tcw_pkg::TCW_WAIT: begin
                r_nxt.cnt = r_r.cnt + 8'h01;
                // Flags stand one cycle, hit_wait counts after the synced address
                if (r_r.cnt == 8'(hit_wait)) begin
                    r_nxt.found = r_r.sval_s2 && r_r.sfnd_s2;
                    r_nxt.st = tcw_pkg::TCW_IDLE;
                    r_nxt.busy = 1'b0;
                    r_nxt.done = 1'b1;
                end
                if (r_r.cnt == 8'(tcw_pkg::SRCH_LAT)) begin
                    r_nxt.res_addr = r_r.sram_s2;
                end
            end
            default: r_nxt.st = tcw_pkg::TCW_IDLE;
        endcase
    end

    // State register; clock enable freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_r <= '0;
        end else if (clk_en) begin
            r_r <= r_nxt;
        end
    end

    assign prdata        = r_r.prdata;
    assign pready        = r_r.pready;
    assign pslverr       = 1'b0;
    assign command_valid = r_r.pins.cmd_valid;
    assign command       = r_r.pins.cmd;
    assign data_bus_out  = r_r.pins.dq_out;
    assign data_bus_oe   = r_r.pins.dq_oe;

    // Write cycle B must follow cycle A with the same code
    a_write_cycle_b: assert property (@(posedge pclk) disable iff (!presetn)
        (clk_en && r_r.st == tcw_pkg::TCW_CYC_A && !is_srch) |=>
        (command_valid && command[1:0] == tcw_pkg::CODE_WRITE))
        else $error("write cycle B lost the command");
    // Search cycles carry code 10
    a_search_code: assert property (@(posedge pclk) disable iff (!presetn)
        (command_valid && is_srch) |-> command[1:0] == tcw_pkg::CODE_SEARCH)
        else $error("search code wrong");
    // Search cycle A drives bit 2 low
    a_search_bit2: assert property (@(posedge pclk) disable iff (!presetn)
        (r_r.st == tcw_pkg::TCW_CYC_A && is_srch) |-> !command[tcw_pkg::CMD_TYPE])
        else $error("search bit 2 high");
    // Write code 01 whenever a write is on the bus
    a_write_code: assert property (@(posedge pclk) disable iff (!presetn)
        (command_valid && !is_srch) |-> command[1:0] == tcw_pkg::CODE_WRITE)
        else $error("write code wrong");
    // Single write: valid two cycles then data on the bus
    a_single_len: assert property (@(posedge pclk) disable iff (!presetn)
        ($rose(command_valid) && !is_srch && !is_burst && clk_en) |->
        ##1 command_valid ##1 (!command_valid && data_bus_oe))
        else $error("single write length wrong");
    // Idle cycle after data drops the bus
    a_tail_idle: assert property (@(posedge pclk) disable iff (!presetn)
        (r_r.st == tcw_pkg::TCW_TAIL) |-> (!data_bus_oe && !command_valid))
        else $error("bus driven in idle cycle");
    // No command while write data is on the bus
    a_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
        (r_r.st == tcw_pkg::TCW_DATA) |-> !command_valid)
        else $error("command during write data");
    // Search key repeated in cycle B
    a_key_repeat: assert property (@(posedge pclk) disable iff (!presetn)
        (r_r.st == tcw_pkg::TCW_CYC_B && is_srch) |-> $stable(data_bus_out))
        else $error("search key changed");

endmodule
`default_nettype wire

/* File: tcw_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tcw_dev_model #(
    parameter logic [4:0] DEV_ID  = 5'h03,
    parameter logic [5:0] CFG_REG = 6'h08
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        command_valid,
    input  wire logic [8:0]  command,
    input  wire logic [67:0] data_bus,
    output logic             burst_end_flag,
    output logic             search_valid_out,
    output logic             search_found_out,
    output logic      [21:0] sram_addr
);
    logic [67:0] ent [16];
    logic [67:0] lm  [16];
    logic [67:0] gm  [8];
    logic [67:0] cev [16];
    logic [67:0] cod [16];
    logic [13:0] rslt [8];
    logic [67:0] key;
    logic [67:0] g;
    logic [31:0] aw;
    logic [8:0]  ca;
    logic [7:0]  k;
    logic [7:0]  bl;
    logic [13:0] ptr;
    logic [13:0] loc;
    logic [13:0] ml;
    logic [21:0] res;
    logic [3:0]  dt;
    logic [3:0]  ft;
    logic [2:0]  hd;
    logic        wr;
    logic        sr;
    logic        hit;
    logic        mh;
    logic        tg;

    // Scan from the top so the hit kept last is the lowest location
    always_comb begin
        mh = 1'b0;
        ml = 14'h0000;
        for (int e = 15; e >= 0; e--) begin
            if (((ent[e] ^ key) & gm[ca[5:3]] & ~lm[e]) == 68'h0) begin
                mh = 1'b1;
                ml = 14'(e);
            end
        end
    end

    // Location decode; indirect form ORs low bits into a stored result
    assign loc = aw[29] ? {rslt[aw[28:26]][13:2], rslt[aw[28:26]][1:0] | aw[1:0]} : aw[13:0];
    assign g = gm[ca[5:3]];
    // Released burst flag and SRAM address lines toggle so a stale level is never mistaken for an answer
    assign burst_end_flag = (wr && ca[2] && k >= 8'h03 && k <= bl + 8'h02) ?
                            (k == bl + 8'h01) : tg;
    assign sram_addr = (dt == 4'h1) ? res : {22{tg}};
    assign search_valid_out = (ft == 4'h1);
    assign search_found_out = (ft == 4'h1) && hit;

    // Command decoder: cycle A opens, write cycle B checks the device number, search cycle B records the answer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr <= 1'b0;
            sr <= 1'b0;
            k <= 8'h00;
            bl <= 8'h01;
            ptr <= 14'h0000;
            hd <= 3'h0;
            dt <= 4'h0;
            ft <= 4'h0;
            tg <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                ent[i] <= {68{1'b1}};
                lm[i] <= 68'h0;
            end
            for (int i = 0; i < 8; i++) begin
                gm[i] <= {68{1'b1}};
            end
        end else begin
            tg <= ~tg;
            k <= k + 8'h01;
            dt <= (dt != 4'h0) ? dt - 4'h1 : dt;
            ft <= (ft != 4'h0) ? ft - 4'h1 : ft;
            if (!wr && !sr && command_valid) begin
                wr <= (command[1:0] == tcw_pkg::CODE_WRITE);
                sr <= (command[1:0] == tcw_pkg::CODE_SEARCH);
                ca <= command;
                key <= data_bus;
                k <= 8'h01;
            end
            if (wr && k == 8'h01) begin
                aw <= data_bus[31:0];
                wr <= (data_bus[25:21] == DEV_ID) || (data_bus[25:21] == tcw_pkg::ID_ALL);
            end
            // Burst data goes to the pointer, arrays only
            if (wr && ca[2] && k >= 8'h02 && k <= bl + 8'h01) begin
                ptr <= ptr + 14'h0001;
                if (aw[20:19] == 2'b00)
                    ent[ptr[3:0]] <= (ent[ptr[3:0]] & ~g) | (data_bus & g);
                if (aw[20:19] == 2'b01)
                    lm[ptr[3:0]] <= (lm[ptr[3:0]] & ~g) | (data_bus & g);
            end
            if (wr && ca[2] && k == bl + 8'h02)
                wr <= 1'b0;
            // Single write takes data in cycle 2; cycle 3 is idle
            if (wr && !ca[2] && k == 8'h02) begin
                wr <= 1'b0;
                case (aw[20:19])
                    2'b00: ent[loc[3:0]] <= (ent[loc[3:0]] & ~g) | (data_bus & g);
                    2'b01: lm[loc[3:0]] <= (lm[loc[3:0]] & ~g) | (data_bus & g);
                    2'b11: begin
                        if (aw[5:0] < 6'h08)
                            gm[aw[2:0]] <= data_bus;
                        if (aw[5:0] == CFG_REG) begin
                            bl <= data_bus[7:0];
                            ptr <= data_bus[21:8];
                            hd <= data_bus[26:24];
                        end
                    end
                    default: ;  // External memory path is not modelled
                endcase
            end
            // Cycle B: keep the key, record the result, schedule the answer
            if (sr && k == 8'h01) begin
                sr <= 1'b0;
                cev[command[5:2]] <= key;
                cod[command[5:2]] <= key;
                rslt[command[8:6]] <= ml;
                res <= {ca[8:6], 5'h00, ml};
                hit <= mh;
                dt <= 4'h3;
                ft <= 4'h3 + {1'b0, hd};
            end
        end
    end
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [4:0]  DEV = 5'h03;
    localparam logic [67:0] K1  = 68'h1_2345_6789_ABCD_EF01;
    localparam logic [67:0] K2  = 68'h2_0000_1111_2222_3333;
    localparam logic [67:0] K3  = 68'h3_0F0F_0F0F_0F0F_0F0F;
    localparam logic [67:0] K4  = 68'h4_AAAA_5555_AAAA_5555;
    localparam logic [67:0] KB  = 68'h5_0000_0000_0000_0100;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        cv;
    logic [8:0]  cmd;
    logic [67:0] dq_o;
    logic [67:0] dq;
    logic        dq_oe;
    logic        bend;
    logic        s_valid;
    logic        s_found;
    logic [21:0] s_addr;
    int          n_errors = 0;
    int          n_checks = 0;

    always #10 pclk = ~pclk;
    // Undriven data bus shows a changing pattern, never a stale value
    assign dq = dq_oe ? dq_o : {68{pclk}};

    tcw_host u_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .command_valid(cv),
        .command(cmd), .data_bus_out(dq_o), .data_bus_oe(dq_oe), .burst_end_flag(bend),
        .search_valid_out(s_valid), .search_found_out(s_found), .sram_addr(s_addr));
    tcw_dev_model u_dev (.pclk(pclk), .presetn(presetn), .command_valid(cv),
        .command(cmd), .data_bus(dq), .burst_end_flag(bend), .search_valid_out(s_valid),
        .search_found_out(s_found), .sram_addr(s_addr));

    task automatic results();
        if (n_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (i >= 50) begin
            n_errors++;
            results();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctl(input logic s, b, input logic [2:0] m, r);
        return {1'b0, 3'h2, 8'h04, 4'h6, 1'b0, r, 1'b0, 3'h5, 1'b0, m, 1'b0, b, s, 1'b0};
    endfunction

    function automatic logic [31:0] aw(input logic [1:0] t, input logic [4:0] id,
                                       input logic [13:0] l);
        return {6'h00, id, t, 5'h00, l};
    endfunction

    // Stage address and data, start the command, wait until busy drops
    task automatic op(input logic [31:0] c, input logic [31:0] a, input logic [67:0] d);
        logic [31:0] rd;
        int i;
        apb(1'b1, tcw_pkg::OFF_ADDR, a, rd);
        apb(1'b1, tcw_pkg::OFF_DATA0, d[31:0], rd);
        apb(1'b1, tcw_pkg::OFF_DATA1, d[63:32], rd);
        apb(1'b1, tcw_pkg::OFF_DATA2, {28'h0, d[67:64]}, rd);
        apb(1'b1, tcw_pkg::OFF_CTRL, c | 32'h1, rd);
        i = 0;
        do begin
            apb(1'b0, tcw_pkg::OFF_STATUS, 32'h0, rd);
            i++;
        end while (rd[0] !== 1'b0 && i < 50);
        if (i >= 50) begin
            n_errors++;
            results();
        end
    endtask

    task automatic srch(input logic [67:0] key, input logic [2:0] r, input logic f,
                        input logic [13:0] l);
        logic [31:0] rd;
        op(ctl(1'b1, 1'b0, 3'h0, r), 32'h0, key);
        apb(1'b0, tcw_pkg::OFF_STATUS, 32'h0, rd);
        chk("found", {31'h0, f}, {31'h0, rd[3]});
        chk("done", 32'h1, {31'h0, rd[1]});
        if (f) begin
            apb(1'b0, tcw_pkg::OFF_RESULT, 32'h0, rd);
            chk("result", {10'h000, 3'h5, 5'h00, l}, rd);
        end
    endtask

    // Main sequence: configure, write, search, burst, indirect, masked writes
    initial begin
        logic [31:0] rd;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, tcw_pkg::OFF_STATUS, 32'h0, rd);
        chk("status", 32'h0, rd);
        apb(1'b0, 8'h1C, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        op(ctl(0, 0, 0, 0), aw(2'h3, 5'h1F, 14'h0008), 68'h0200_0A04);
        op(ctl(0, 0, 0, 0), aw(2'h0, DEV, 14'd5), K1);
        op(ctl(0, 0, 0, 0), aw(2'h0, 5'h1F, 14'd9), K1);
        op(ctl(0, 0, 0, 0), aw(2'h0, 5'h07, 14'd3), K1);
        op(ctl(0, 0, 0, 0), aw(2'h0, DEV, 14'd1), K2);
        srch(K1, 3'h2, 1'b1, 14'd5);
        srch(K2, 3'h0, 1'b1, 14'd1);
        srch(K4, 3'h0, 1'b0, 14'd0);
        op(ctl(0, 1, 0, 0), aw(2'h0, DEV, 14'd0), KB);
        apb(1'b0, tcw_pkg::OFF_STATUS, 32'h0, rd);
        chk("burst_end", 32'h1, {31'h0, rd[2]});
        srch(KB + 68'h3, 3'h0, 1'b1, 14'd13);
        srch(KB, 3'h0, 1'b1, 14'd10);
        op(ctl(0, 0, 0, 0), aw(2'h0, DEV, 14'd0) | 32'h2800_0002, K3);
        srch(K3, 3'h0, 1'b1, 14'd7);
        op(ctl(0, 0, 0, 0), aw(2'h3, DEV, 14'd1), 68'hF);
        op(ctl(0, 0, 3'h1, 0), aw(2'h0, DEV, 14'd5), 68'h0);
        srch(K1, 3'h0, 1'b1, 14'd9);
        srch(K1 & ~68'hF, 3'h0, 1'b1, 14'd5);
        op(ctl(0, 0, 0, 0), aw(2'h1, DEV, 14'd9), {68{1'b1}});
        srch(K4, 3'h0, 1'b1, 14'd9);
        results();
    end
endmodule
`default_nettype wire
